// ### core/cfmfc_core.sv
// Frame-format, operating-mode and exception control for a CAN FD controller
//
// Design decisions made here: the address map and the Avalon-MM register port.
`default_nettype none
// Operation
// - Length code and data byte count stay exact despite identifier stuff bits.
// - Non-zero FD enable enables FD; zero means classic only.
// - Mode request field clears to zero once taken.
// - Readable flags show FD and bit rate switching active.
// - Received arbitration bits never replaced by pending transmit bits.
// - Good received frames go to the receive handler.
// - Zero segment two and prescaler give one-quantum segment, one-clock quantum.
// - Classic extended frames send the reserved bit after remote request dominant.
// - FD frames send FDF recessive and the whole frame in FD format.
// - FDF and following reserved bit recessive: exception event, frame discarded.
// - Next frame after an exception is handled normally.
// - Storage failure flag set only by a real storage failure.
// - Transmit event entry format flags match the frame actually sent.
// - Storage failure during transmit enters restricted operation and aborts it.
module cfmfc_core (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	// Avalon-MM slave
	input  wire logic [4:0]                    address,
	input  wire logic                          read,
	input  wire logic                          write,
	input  wire logic [3:0]                    byteenable,
	input  wire logic [31:0]                   writedata,
	output logic [31:0]                        readdata,
	output logic                               waitrequest,
	output logic                               irq,
	// Transmit handler side
	input  wire logic                          tx_start,
	input  wire cfmfc_pkg::cfmfc_tx_req_type   tx_req,
	input  wire logic                          tx_done,
	input  wire logic [31:0]                   tx_buffer_pending_bits,
	output logic                               tx_ready,
	output cfmfc_pkg::cfmfc_tx_ctrl_type       tx_ctrl,
	output logic                               tx_abort,
	output logic                               tx_event_valid,
	output cfmfc_pkg::cfmfc_tx_event_type      tx_event,
	// Receive decoder side
	input  wire logic                          rx_sof,
	input  wire logic                          rx_hdr_valid,
	input  wire cfmfc_pkg::cfmfc_rx_hdr_type   rx_hdr_in,
	input  wire logic                          rx_frame_end,
	input  wire logic                          rx_frame_ok,
	output logic                               rx_deliver,
	output logic                               rx_discard,
	output cfmfc_pkg::cfmfc_rx_hdr_type        rx_hdr,
	// Storage and bit timing
	input  wire logic                          msg_store_fail,
	input  wire logic                          sample_point,
	output logic                               tq_tick,
	output logic                               seg2_done
);
	// ==========================================================
	// State
	logic [31:0]               readdata_reg;
	logic                      waitrequest_reg;
	logic                      irq_reg;
	logic [1:0]                fd_enable_field_reg;
	logic [1:0]                mode_change_request_field_reg;
	logic                      restricted_reg;
	logic [8:0]                quantum_prescaler_field_reg;
	logic [6:0]                phase_seg_two_field_reg;
	logic [cfmfc_pkg::ST_W-1:0] status_reg;
	logic [cfmfc_pkg::ST_W-1:0] mask_reg;
	cfmfc_pkg::cfmfc_mode_type mode_reg;
	logic                      tx_busy_reg, tx_ready_reg, tx_abort_reg, tx_event_valid_reg;
	cfmfc_pkg::cfmfc_tx_ctrl_type  tx_ctrl_reg;
	cfmfc_pkg::cfmfc_tx_event_type tx_event_reg;
	logic                      rx_active_reg, rx_held_reg, rx_deliver_reg, rx_discard_reg;
	cfmfc_pkg::cfmfc_rx_hdr_type   rx_hdr_reg;
	logic [8:0]                presc_cnt_reg;
	logic                      tq_tick_reg;
	logic [6:0]                seg2_cnt_reg;
	logic                      seg2_run_reg, seg2_done_reg;

	// Merge write data into an old value under the byte enables
	function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_be

	// ==========================================================
	// Bus decode
	logic        wr_acc, rd_acc, fd_on, tx_take, bus_idle;
	logic [31:0] mode_word, timing_word, wr_mode, wr_timing, wr_status, wr_mask;
	logic [cfmfc_pkg::ST_W-1:0] events;

	// A write is acted on in the cycle waitrequest is low, a read in the wait cycle before it
	assign wr_acc = write && !waitrequest_reg;
	assign rd_acc = read && waitrequest_reg;
	assign fd_on  = (fd_enable_field_reg != 2'h0);
	assign bus_idle = !tx_busy_reg && !rx_active_reg && !rx_sof && !tx_start;
	assign tx_take = tx_start && tx_ready_reg;

	// Register images as software sees them
	always_comb begin
		mode_word = 32'h0000_0000;
		mode_word[cfmfc_pkg::FDE_LSB +: 2] = fd_enable_field_reg;
		mode_word[cfmfc_pkg::CMR_LSB +: 2] = mode_change_request_field_reg;
		mode_word[cfmfc_pkg::FDO_BIT]  = fd_on && (mode_reg != cfmfc_pkg::MODE_CLASSIC);
		mode_word[cfmfc_pkg::FDBS_BIT] = fd_on && (mode_reg == cfmfc_pkg::MODE_FD_BRS);
		mode_word[cfmfc_pkg::RESTR_BIT] = restricted_reg;
		timing_word = 32'h0000_0000;
		timing_word[cfmfc_pkg::PRESC_LSB +: 9] = quantum_prescaler_field_reg;
		timing_word[cfmfc_pkg::SEG2_LSB +: 7]  = phase_seg_two_field_reg;
	end

	assign wr_mode   = merge_be(mode_word, writedata, byteenable);
	assign wr_timing = merge_be(timing_word, writedata, byteenable);
	assign wr_status = merge_be(32'h0000_0000, writedata, byteenable);
	assign wr_mask   = merge_be({28'h0000000, mask_reg}, writedata, byteenable);

	// Handshake: one wait cycle, then the access completes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			waitrequest_reg <= 1'b1;
		end else begin
			waitrequest_reg <= !((read || write) && waitrequest_reg);
		end
	end

	// Read data loaded in the wait cycle; unmapped reads zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readdata_reg <= 32'h0000_0000;
		end else if (rd_acc) begin
			case (address)
				cfmfc_pkg::OFF_MODE:    readdata_reg <= mode_word;
				cfmfc_pkg::OFF_TIMING:  readdata_reg <= timing_word;
				cfmfc_pkg::OFF_STATUS:  readdata_reg <= {28'h0000000, status_reg};
				cfmfc_pkg::OFF_MASK:    readdata_reg <= {28'h0000000, mask_reg};
				cfmfc_pkg::OFF_PENDING: readdata_reg <= tx_buffer_pending_bits;
				default:                readdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Mode control
	// Configuration fields written by software
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fd_enable_field_reg         <= cfmfc_pkg::FDE_RST;
			quantum_prescaler_field_reg <= cfmfc_pkg::PRESC_RST;
			phase_seg_two_field_reg     <= cfmfc_pkg::SEG2_RST;
			mask_reg                    <= '0;
		end else if (wr_acc) begin
			if (address == cfmfc_pkg::OFF_MODE) begin
				fd_enable_field_reg <= wr_mode[cfmfc_pkg::FDE_LSB +: 2];
			end
			if (address == cfmfc_pkg::OFF_TIMING) begin
				quantum_prescaler_field_reg <= wr_timing[cfmfc_pkg::PRESC_LSB +: 9];
				phase_seg_two_field_reg     <= wr_timing[cfmfc_pkg::SEG2_LSB +: 7];
			end
			if (address == cfmfc_pkg::OFF_MASK) begin
				mask_reg <= wr_mask[cfmfc_pkg::ST_W-1:0];
			end
		end
	end

	// Requests are held, applied between frames, then acknowledged by clearing
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_change_request_field_reg <= cfmfc_pkg::CMR_NONE;
			mode_reg                      <= cfmfc_pkg::MODE_CLASSIC;
		end else begin
			if (!fd_on) begin
				mode_reg <= cfmfc_pkg::MODE_CLASSIC;
			end
			if (wr_acc && address == cfmfc_pkg::OFF_MODE) begin
				mode_change_request_field_reg <= wr_mode[cfmfc_pkg::CMR_LSB +: 2];
			end else if (mode_change_request_field_reg != cfmfc_pkg::CMR_NONE && bus_idle) begin
				// A new write wins over the acknowledge, so no request is lost
				mode_change_request_field_reg <= cfmfc_pkg::CMR_NONE;
				if (fd_on) begin
					case (mode_change_request_field_reg)
						cfmfc_pkg::CMR_FD:     mode_reg <= cfmfc_pkg::MODE_FD;
						cfmfc_pkg::CMR_FD_BRS: mode_reg <= cfmfc_pkg::MODE_FD_BRS;
						default:               mode_reg <= cfmfc_pkg::MODE_CLASSIC;
					endcase
				end
			end
		end
	end

	// ==========================================================
	// Transmit path
	// Restricted: set by storage failure mid-transmit, cleared by writing zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			restricted_reg <= 1'b0;
		end else if (msg_store_fail && tx_busy_reg) begin
			restricted_reg <= 1'b1;
		end else if (wr_acc && address == cfmfc_pkg::OFF_MODE) begin
			restricted_reg <= restricted_reg & wr_mode[cfmfc_pkg::RESTR_BIT];
		end
	end

	// Frame format is frozen at start so later mode changes cannot touch it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_busy_reg  <= 1'b0;
			tx_abort_reg <= 1'b0;
			tx_ctrl_reg  <= '0;
			tx_event_reg <= '0;
		end else begin
			tx_abort_reg <= 1'b0;
			if (tx_busy_reg && msg_store_fail) begin
				tx_busy_reg  <= 1'b0;
				tx_abort_reg <= 1'b1;
			end else if (tx_busy_reg && tx_done) begin
				tx_busy_reg <= 1'b0;
			end else if (tx_take) begin
				tx_busy_reg <= 1'b1;
				tx_ctrl_reg.ide <= tx_req.ext_id;
				tx_ctrl_reg.res_after_rtr <= cfmfc_pkg::DOMINANT;
				tx_ctrl_reg.dlc <= tx_req.dlc;
				if (tx_req.want_fd && mode_reg != cfmfc_pkg::MODE_CLASSIC && fd_on) begin
					tx_ctrl_reg.fdf <= cfmfc_pkg::RECESSIVE;
					tx_ctrl_reg.brs <= tx_req.want_brs && mode_reg == cfmfc_pkg::MODE_FD_BRS;
					tx_event_reg.extended_length_flag <= 1'b1;
					tx_event_reg.brs <= tx_req.want_brs && mode_reg == cfmfc_pkg::MODE_FD_BRS;
				end else begin
					tx_ctrl_reg.fdf <= cfmfc_pkg::DOMINANT;
					tx_ctrl_reg.brs <= 1'b0;
					tx_event_reg    <= '0;
				end
			end
		end
	end

	// Ready drops when a frame is taken or restriction starts
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_ready_reg       <= 1'b0;
			tx_event_valid_reg <= 1'b0;
		end else begin
			tx_ready_reg <= !restricted_reg && !(msg_store_fail && tx_busy_reg)
				&& !(tx_busy_reg && !tx_done) && !tx_take;
			tx_event_valid_reg <= tx_busy_reg && tx_done && !msg_store_fail;
		end
	end

	// ==========================================================
	// Receive path
	// Header comes only from received bits, never from pending transmit data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_active_reg  <= 1'b0;
			rx_held_reg    <= 1'b0;
			rx_deliver_reg <= 1'b0;
			rx_discard_reg <= 1'b0;
			rx_hdr_reg     <= '0;
		end else begin
			rx_deliver_reg <= 1'b0;
			rx_discard_reg <= 1'b0;
			if (rx_sof) begin
				rx_active_reg <= 1'b1;
				rx_held_reg   <= 1'b0;
			end else if (rx_hdr_valid && rx_active_reg) begin
				if (rx_hdr_in.fdf == cfmfc_pkg::RECESSIVE && rx_hdr_in.res == cfmfc_pkg::RECESSIVE) begin
					rx_active_reg  <= 1'b0;
					rx_held_reg    <= 1'b0;
					rx_discard_reg <= 1'b1;
				end else begin
					rx_hdr_reg  <= rx_hdr_in;
					rx_held_reg <= 1'b1;
				end
			end else if (rx_frame_end && rx_active_reg) begin
				rx_active_reg  <= 1'b0;
				rx_held_reg    <= 1'b0;
				rx_deliver_reg <= rx_held_reg && rx_frame_ok;
			end
		end
	end

	// ==========================================================
	// Bit timing: quantum is prescaler+1 clocks, segment two is field+1 quanta
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			presc_cnt_reg <= 9'h000;
			tq_tick_reg   <= 1'b0;
		end else if (presc_cnt_reg >= quantum_prescaler_field_reg) begin
			presc_cnt_reg <= 9'h000;
			tq_tick_reg   <= 1'b1;
		end else begin
			presc_cnt_reg <= presc_cnt_reg + 9'h001;
			tq_tick_reg   <= 1'b0;
		end
	end

	// Segment two counts quanta after each sample point
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seg2_cnt_reg  <= 7'h00;
			seg2_run_reg  <= 1'b0;
			seg2_done_reg <= 1'b0;
		end else begin
			seg2_done_reg <= 1'b0;
			if (sample_point) begin
				seg2_run_reg <= 1'b1;
				seg2_cnt_reg <= 7'h00;
			end else if (seg2_run_reg && tq_tick_reg) begin
				if (seg2_cnt_reg >= phase_seg_two_field_reg) begin
					seg2_run_reg  <= 1'b0;
					seg2_done_reg <= 1'b1;
				end else begin
					seg2_cnt_reg <= seg2_cnt_reg + 7'h01;
				end
			end
		end
	end

	// ==========================================================
	// Interrupts: sticky events, write one to clear, set wins over clear
	assign events = {tx_busy_reg && tx_done && !msg_store_fail,
		rx_deliver_reg, msg_store_fail, rx_discard_reg};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_reg <= '0;
			irq_reg    <= 1'b0;
		end else begin
			if (wr_acc && address == cfmfc_pkg::OFF_STATUS) begin
				status_reg <= (status_reg & ~wr_status[cfmfc_pkg::ST_W-1:0]) | events;
			end else begin
				status_reg <= status_reg | events;
			end
			irq_reg <= |(status_reg & mask_reg);
		end
	end

	// ==========================================================
	// Outputs
	assign readdata       = readdata_reg;
	assign waitrequest    = waitrequest_reg;
	assign irq            = irq_reg;
	assign tx_ready       = tx_ready_reg;
	assign tx_ctrl        = tx_ctrl_reg;
	assign tx_abort       = tx_abort_reg;
	assign tx_event_valid = tx_event_valid_reg;
	assign tx_event       = tx_event_reg;
	assign rx_deliver     = rx_deliver_reg;
	assign rx_discard     = rx_discard_reg;
	assign rx_hdr         = rx_hdr_reg;
	assign tq_tick        = tq_tick_reg;
	assign seg2_done      = seg2_done_reg;
endmodule : cfmfc_core
`default_nettype wire

// ### core/cfmfc_pkg.sv
// Constants and carrier types for the CAN frame-format control block
`default_nettype none
package cfmfc_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [4:0] OFF_MODE    = 5'h00;
	localparam logic [4:0] OFF_TIMING  = 5'h04;
	localparam logic [4:0] OFF_STATUS  = 5'h08;
	localparam logic [4:0] OFF_MASK    = 5'h0c;
	localparam logic [4:0] OFF_PENDING = 5'h10;
	// ==========================================================
	// Mode register fields
	localparam int FDE_LSB   = 0;  // fd_enable_field, 2 bits
	localparam int CMR_LSB   = 4;  // mode_change_request_field, 2 bits
	localparam int FDO_BIT   = 8;  // fd_active_flag
	localparam int FDBS_BIT  = 9;  // bitrate_switch_active_flag
	localparam int RESTR_BIT = 12; // Restricted operation
	// Timing register fields
	localparam int PRESC_LSB = 0;  // quantum_prescaler_field, 9 bits
	localparam int SEG2_LSB  = 16; // phase_seg_two_field, 7 bits
	// Status and mask bits
	localparam int ST_PEX    = 0;
	localparam int ST_MRAF   = 1;  // msg_store_access_fail_flag
	localparam int ST_RXOK   = 2;
	localparam int ST_TXDONE = 3;
	localparam int ST_W      = 4;
	// ==========================================================
	// Reset values and encodings
	localparam logic [1:0] FDE_RST     = 2'h0;
	localparam logic [8:0] PRESC_RST   = 9'h000;
	localparam logic [6:0] SEG2_RST    = 7'h01;
	localparam logic [1:0] CMR_NONE    = 2'h0;
	localparam logic [1:0] CMR_FD      = 2'h1;
	localparam logic [1:0] CMR_FD_BRS  = 2'h2;
	localparam logic [1:0] CMR_CLASSIC = 2'h3;
	localparam logic       DOMINANT    = 1'b0;
	localparam logic       RECESSIVE   = 1'b1;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {MODE_CLASSIC, MODE_FD, MODE_FD_BRS} cfmfc_mode_type;
	typedef struct packed {
		logic       ext_id;
		logic       rtr;
		logic       want_fd;
		logic       want_brs;
		logic [3:0] dlc;
	} cfmfc_tx_req_type;
	typedef struct packed {
		logic       ide;
		logic       res_after_rtr;
		logic       fdf;
		logic       brs;
		logic [3:0] dlc;
	} cfmfc_tx_ctrl_type;
	typedef struct packed {
		logic extended_length_flag;
		logic brs;
	} cfmfc_tx_event_type;
	typedef struct packed {
		logic [28:0] id;
		logic        ide;
		logic        fdf;
		logic        res;
		logic [3:0]  dlc;
	} cfmfc_rx_hdr_type;
endpackage : cfmfc_pkg
`default_nettype wire

// ### tb/cfmfc_chk.sv
// Port-level assertions for the frame-format control block
`default_nettype none
module cfmfc_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register bus
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	// Transmit side
	input wire logic tx_start,
	input wire cfmfc_pkg::cfmfc_tx_req_type tx_req,
	input wire logic tx_done,
	input wire logic tx_ready,
	input wire cfmfc_pkg::cfmfc_tx_ctrl_type tx_ctrl,
	input wire logic tx_abort,
	input wire logic tx_event_valid,
	input wire cfmfc_pkg::cfmfc_tx_event_type tx_event,
	// Receive side
	input wire logic rx_hdr_valid,
	input wire cfmfc_pkg::cfmfc_rx_hdr_type rx_hdr_in,
	input wire logic rx_deliver,
	input wire logic rx_discard,
	// Storage and timing
	input wire logic msg_store_fail,
	input wire logic sample_point,
	input wire logic seg2_done
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// ========
	// Shared steps
	sequence s_tx_take;
		tx_start && tx_ready;
	endsequence
	sequence s_exc_hdr;
		rx_hdr_valid && rx_hdr_in.fdf && rx_hdr_in.res;
	endsequence
	// ========
	// One wait cycle, one ready cycle
	a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("late bus answer");
	a_bus_ready_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("long bus ready");
	// Accepted frame keeps its control bits
	a_tx_take_dlc: assert property (s_tx_take |=> !tx_ready && tx_ctrl.dlc == $past(tx_req.dlc)
		&& tx_ctrl.ide == $past(tx_req.ext_id)) else $error("dlc or id lost");
	a_tx_res_dominant: assert property (s_tx_take |=> tx_ctrl.fdf || !tx_ctrl.ide
		|| tx_ctrl.res_after_rtr == cfmfc_pkg::DOMINANT) else $error("res not dominant");
	a_event_format: assert property (tx_event_valid |->
		tx_event.extended_length_flag == tx_ctrl.fdf && tx_event.brs == tx_ctrl.brs)
		else $error("event flags wrong");
	a_done_event: assert property (tx_done && !tx_ready && !msg_store_fail |=>
		tx_event_valid && tx_ready) else $error("no tx event");
	// Mid-frame storage failure aborts and locks transmit
	a_fail_abort: assert property (msg_store_fail && !tx_ready |=> tx_abort ##1 !tx_ready)
		else $error("no abort");
	// Exception header discards the frame
	a_exc_discard: assert property (s_exc_hdr |=> rx_discard && !rx_deliver)
		else $error("no discard");
	a_no_spurious: assert property (rx_discard |=> !rx_deliver [*8])
		else $error("spurious deliver");
	// Only small timing settings are exercised, so a fixed bound suffices
	a_seg2_bound: assert property (sample_point |-> ##[1:1000] seg2_done)
		else $error("seg2 never ends");
endmodule : cfmfc_chk
bind cfmfc_core cfmfc_chk u_chk (.clk, .rst_b, .read, .write, .waitrequest, .tx_start,
	.tx_req, .tx_done, .tx_ready, .tx_ctrl, .tx_abort, .tx_event_valid, .tx_event,
	.rx_hdr_valid, .rx_hdr_in, .rx_deliver, .rx_discard, .msg_store_fail, .sample_point,
	.seg2_done);
`default_nettype wire

// ### tb/cfmfc_bus_node.sv
// Model of the remote bus nodes behind the decoder and handler
`default_nettype none
module cfmfc_bus_node (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Bench commands
	input wire logic rx_go,
	input wire cfmfc_pkg::cfmfc_rx_hdr_type hdr_set,
	input wire logic [7:0] tx_len,
	// Block side
	input wire logic tx_ready,
	output logic rx_sof,
	output logic rx_hdr_valid,
	output cfmfc_pkg::cfmfc_rx_hdr_type rx_hdr_in,
	output logic rx_frame_end,
	output logic rx_frame_ok,
	output logic tx_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] rx_cnt;
	logic [7:0] tx_cnt;
	logic tx_ready_q;
	// ========
	// Received frame: start, header, end four cycles later
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{rx_cnt, rx_sof, rx_hdr_valid, rx_frame_end, rx_frame_ok, rx_hdr_in} <= '0;
		end else begin
			rx_cnt <= rx_go ? 3'h1 : (rx_cnt == 3'h0 ? 3'h0 : rx_cnt + 3'h1);
			rx_sof <= rx_go;
			rx_hdr_valid <= rx_cnt == 3'h1;
			rx_frame_end <= rx_cnt == 3'h5;
			rx_frame_ok <= rx_cnt == 3'h5;
			// Lines toggle outside the header so a stale copy never matches
			rx_hdr_in <= rx_cnt == 3'h1 ? hdr_set : ~rx_hdr_in;
		end
	end
	// Frame on the bus ends tx_len cycles after it started; zero stalls forever
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{tx_cnt, tx_ready_q, tx_done} <= '0;
		end else begin
			tx_ready_q <= tx_ready;
			tx_done <= tx_cnt == 8'h01;
			if (tx_cnt != 8'h00) begin
				tx_cnt <= tx_cnt - 8'h01;
			end else if (tx_ready_q && !tx_ready) begin
				tx_cnt <= tx_len;
			end
		end
	end
endmodule : cfmfc_bus_node
`default_nettype wire

// ### tb/tb_cfmfc_core.sv
// Self-checking bench for the frame-format control block
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
`define WAITF(c) begin int k; for (k = 0; k < 200 && !(c); k++) @(negedge clk); \
	if (!(c)) timed_out(); end
module tb_cfmfc_core;
	timeunit 1ns;
	timeprecision 1ns;
	// ========
	// Design and model connections
	logic clk, rst_b, read, write, waitrequest, irq;
	logic [4:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, tx_buffer_pending_bits, rd;
	logic tx_start, tx_done, tx_ready, tx_abort, tx_event_valid, msg_store_fail;
	cfmfc_pkg::cfmfc_tx_req_type tx_req;
	cfmfc_pkg::cfmfc_tx_ctrl_type tx_ctrl;
	cfmfc_pkg::cfmfc_tx_event_type tx_event;
	logic rx_sof, rx_hdr_valid, rx_frame_end, rx_frame_ok, rx_deliver, rx_discard, rx_go;
	cfmfc_pkg::cfmfc_rx_hdr_type rx_hdr_in, rx_hdr, hdr_set;
	logic sample_point, tq_tick, seg2_done;
	logic [7:0] tx_len;
	int n_mismatch = 0;
	int n_checks = 0;
	cfmfc_core dut (.clk, .rst_b, .address, .read, .write, .byteenable, .writedata,
		.readdata, .waitrequest, .irq, .tx_start, .tx_req, .tx_done, .tx_buffer_pending_bits,
		.tx_ready, .tx_ctrl, .tx_abort, .tx_event_valid, .tx_event, .rx_sof, .rx_hdr_valid,
		.rx_hdr_in, .rx_frame_end, .rx_frame_ok, .rx_deliver, .rx_discard, .rx_hdr,
		.msg_store_fail, .sample_point, .tq_tick, .seg2_done);
	cfmfc_bus_node u_node (.clk, .rst_b, .rx_go, .hdr_set, .tx_len, .tx_ready, .rx_sof,
		.rx_hdr_valid, .rx_hdr_in, .rx_frame_end, .rx_frame_ok, .tx_done);
	// ========
	// Verdict and bounded-wait expiry
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	task automatic timed_out();
		n_mismatch++;
		$display("Error wait expected handshake seen timeout");
		end_of_test();
	endtask : timed_out
	// One register access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		{address, writedata, write, read} <= {a, d, w, !w};
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) break;
		end
		if (i == 20) timed_out();
		rd = readdata;
		{write, read} <= 2'b00;
	endtask : bus
	// Start one frame and judge its control bits and event entry
	task automatic t_tx(input cfmfc_pkg::cfmfc_tx_req_type r, input logic fdf, input logic brs);
		@(posedge clk);
		{tx_req, tx_start} <= {r, 1'b1};
		@(posedge clk);
		tx_start <= 1'b0;
		`WAITF(tx_event_valid)
		`CHK("fdf", fdf, tx_ctrl.fdf)
		`CHK("brs", brs, tx_ctrl.brs)
		`CHK("dlc", r.dlc, tx_ctrl.dlc)
		if (r.ext_id && !fdf) `CHK("res", cfmfc_pkg::DOMINANT, tx_ctrl.res_after_rtr)
		`CHK("event", {fdf, brs}, tx_event)
		$display("frame test done");
	endtask : t_tx
	// Reset values, read-only pending word and an unmapped place
	task automatic t_reset();
		tx_buffer_pending_bits <= 32'h0000_00a5;
		bus(1'b0, cfmfc_pkg::OFF_MODE, 32'h0);
		`CHK("mode", 32'h0, rd)
		bus(1'b0, cfmfc_pkg::OFF_TIMING, 32'h0);
		`CHK("timing", {9'h0, cfmfc_pkg::SEG2_RST, 7'h0, cfmfc_pkg::PRESC_RST}, rd)
		bus(1'b0, cfmfc_pkg::OFF_PENDING, 32'h0);
		`CHK("pending", 32'h0000_00a5, rd)
		bus(1'b0, 5'h14, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		tx_buffer_pending_bits <= 32'h0;
		$display("reset test done");
	endtask : t_reset
	// Every request code with FD enabled, and CMR_FD_BRS also with FD disabled
	task automatic t_mode();
		logic [1:0] fde[6] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h3};
		logic [1:0] req[6] = '{cfmfc_pkg::CMR_FD, cfmfc_pkg::CMR_FD_BRS, cfmfc_pkg::CMR_CLASSIC,
			cfmfc_pkg::CMR_FD_BRS, cfmfc_pkg::CMR_FD, cfmfc_pkg::CMR_FD_BRS};
		int i, j;
		for (i = 0; i < 6; i++) begin
			bus(1'b1, cfmfc_pkg::OFF_MODE, {26'h0, req[i], 2'h0, fde[i]});
			for (j = 0; j < 4; j++) begin
				bus(1'b0, cfmfc_pkg::OFF_MODE, 32'h0);
				if (rd[5:4] === 2'h0) break;
			end
			`CHK("cmr", 2'h0, rd[5:4])
			`CHK("fdo", fde[i] != 2'h0 && req[i] != cfmfc_pkg::CMR_CLASSIC, rd[8])
			`CHK("fdbs", fde[i] != 2'h0 && req[i] == cfmfc_pkg::CMR_FD_BRS, rd[9])
		end
		$display("mode test done");
	endtask : t_mode
	// Mode request made mid-frame waits for the frame to end
	task automatic t_defer();
		tx_len <= 8'h28;
		@(posedge clk);
		{tx_req, tx_start} <= {8'h34, 1'b1};
		@(posedge clk);
		tx_start <= 1'b0;
		bus(1'b1, cfmfc_pkg::OFF_MODE, 32'h0000_0033);
		bus(1'b0, cfmfc_pkg::OFF_MODE, 32'h0);
		`CHK("held", 32'h0000_0333, rd)
		`WAITF(tx_event_valid)
		`CHK("event", 2'h3, tx_event)
		bus(1'b0, cfmfc_pkg::OFF_MODE, 32'h0);
		`CHK("applied", 32'h0000_0003, rd)
		tx_len <= 8'h06;
		$display("defer test done");
	endtask : t_defer
	// Exception frame then a good frame whose id ends in dominant bits
	task automatic t_rx();
		bus(1'b1, cfmfc_pkg::OFF_STATUS, 32'h0000_000f);
		{hdr_set, rx_go, tx_buffer_pending_bits} <= {29'h123, 3'h3, 4'h2, 1'b1, 32'h1};
		@(posedge clk);
		rx_go <= 1'b0;
		`WAITF(rx_discard)
		`CHK("deliver", 1'b0, rx_deliver)
		repeat (10) @(posedge clk);
		{hdr_set, rx_go} <= {29'h1fff_fff8, 3'h4, 4'h3, 1'b1};
		@(posedge clk);
		rx_go <= 1'b0;
		`WAITF(rx_deliver)
		`CHK("hdr", {29'h1fff_fff8, 3'h4, 4'h3}, rx_hdr)
		bus(1'b0, cfmfc_pkg::OFF_STATUS, 32'h0);
		`CHK("status", 32'h0000_0005, rd)
		tx_buffer_pending_bits <= 32'h0;
		$display("receive test done");
	endtask : t_rx
	// Storage failure mid-frame, interrupt masking, clearing and recovery
	task automatic t_fail();
		`CHK("irq", 1'b0, irq)
		bus(1'b1, cfmfc_pkg::OFF_MASK, 32'h0000_0002);
		{tx_len, tx_req, tx_start} <= {8'h00, 8'h02, 1'b1};
		@(posedge clk);
		tx_start <= 1'b0;
		repeat (3) @(posedge clk);
		msg_store_fail <= 1'b1;
		@(posedge clk);
		msg_store_fail <= 1'b0;
		`WAITF(tx_abort)
		bus(1'b0, cfmfc_pkg::OFF_STATUS, 32'h0);
		`CHK("status", 32'h0000_0007, rd)
		`CHK("irq", 1'b1, irq)
		bus(1'b0, cfmfc_pkg::OFF_MODE, 32'h0);
		`CHK("restricted", 1'b1, rd[cfmfc_pkg::RESTR_BIT])
		`CHK("ready", 1'b0, tx_ready)
		bus(1'b1, cfmfc_pkg::OFF_STATUS, 32'h0000_0002);
		`WAITF(irq === 1'b0)
		bus(1'b1, cfmfc_pkg::OFF_MODE, 32'h0000_0003);
		`WAITF(tx_ready === 1'b1)
		tx_len <= 8'h06;
		$display("failure test done");
	endtask : t_fail
	// Zero segment two and prescaler: one-clock quantum, bits still right
	task automatic t_timing();
		int i;
		int n = 0;
		bus(1'b1, cfmfc_pkg::OFF_TIMING, 32'h0);
		for (i = 0; i < 8; i++) begin
			@(negedge clk);
			n += int'(tq_tick === 1'b1);
		end
		`CHK("ticks", 8, n)
		@(posedge clk);
		sample_point <= 1'b1;
		@(posedge clk);
		sample_point <= 1'b0;
		for (i = 0; i < 3 && seg2_done !== 1'b1; i++) @(negedge clk);
		`CHK("seg2", 1'b1, seg2_done)
		t_tx({1'b1, 1'b0, 1'b0, 1'b0, 4'h5}, cfmfc_pkg::DOMINANT, 1'b0);
		bus(1'b1, cfmfc_pkg::OFF_TIMING, 32'h0003_0001);
		$display("timing test done");
	endtask : t_timing
	// ========
	// Clock and main sequence
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{rst_b, read, write, tx_start, rx_go, msg_store_fail, sample_point} = '0;
		{address, writedata, tx_buffer_pending_bits, tx_req, hdr_set} = '0;
		byteenable = 4'hf;
		tx_len = 8'h06;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_mode();
		t_tx({1'b0, 1'b0, 1'b1, 1'b1, 4'hf}, cfmfc_pkg::RECESSIVE, 1'b1);
		t_tx({1'b1, 1'b0, 1'b0, 1'b0, 4'h8}, cfmfc_pkg::DOMINANT, 1'b0);
		t_tx({1'b0, 1'b0, 1'b1, 1'b0, 4'h9}, cfmfc_pkg::RECESSIVE, 1'b0);
		t_defer();
		t_rx();
		t_fail();
		t_timing();
		end_of_test();
	end
endmodule : tb_cfmfc_core
`default_nettype wire
